//--- acc_defines.svh
// Purpose: register indices, field positions, reset values and widths
// Assumes: included by every design file of the alert check config block
// Notes:   byte address of a register is four times its index
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
// register indices
`define ACC_IDX_HOT_EN   8'h1d
`define ACC_IDX_CAL_FRC  8'h1e
`define ACC_IDX_OV_CLR   8'h1f
`define ACC_IDX_OV_SET   8'h20
`define ACC_IDX_AUX_CFG  8'h30
`define ACC_IDX_IRQ_STAT 8'h31
`define ACC_IDX_IRQ_MASK 8'h32
// widths
`define ACC_NAUX   6
`define ACC_NCAL   5
`define ACC_NCELL  14
`define ACC_TW     14
`define ACC_NSTAT  12
`define ACC_CHW    3
`define ACC_CELLW  4
// field positions
`define ACC_THR_LSB    2
`define ACC_REFSEL_LSB 0
`define ACC_IOMODE_LSB 8
`define ACC_ST_HOT_LSB 0
`define ACC_ST_OV_BIT  6
`define ACC_ST_CAL_LSB 7
// reset values and responses
`define ACC_THR_RESET  14'h3fff
`define ACC_RESP_OKAY  2'h0
`define ACC_RESP_SLVERR 2'h2
`endif

//--- acc_pkg.sv
// Purpose: types shared by the alert check config block
// Assumes: acc_defines.svh supplies the widths
// Notes:   the top keeps all of its state in acc_regs_t
`include "acc_defines.svh"
package acc_pkg;
    typedef struct packed {
        logic                    awready;
        logic                    wready;
        logic                    arready;
        logic                    aw_held;
        logic [11:0]             aw_addr;
        logic                    w_held;
        logic [15:0]             w_data;
        logic [1:0]              w_strb;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [1:0]              rresp;
        logic [31:0]             rdata;
        logic [`ACC_NAUX-1:0]    hot_en;
        logic [`ACC_NAUX-1:0]    hot_clr;
        logic [`ACC_NCAL-1:0]    cal_frc;
        logic [`ACC_NCAL-1:0]    cal_alert;
        logic [`ACC_TW-1:0]      ov_clr;
        logic [`ACC_TW-1:0]      ov_set;
        logic [`ACC_NAUX-1:0]    ref_sel;
        logic [`ACC_NAUX-1:0]    io_mode;
        logic [`ACC_NSTAT-1:0]   irq_stat;
        logic [`ACC_NSTAT-1:0]   irq_mask;
        logic                    irq;
    } acc_regs_t;
endpackage : acc_pkg

//--- acc_hot_check.sv
// Purpose: auxiliary hot (undervoltage) fault check, one alert per channel
// Assumes: one aux sample per cycle at most, from the scan engine
// Notes:   an alert stays until its enable bit is cleared
`timescale 1ns/1ps
`include "acc_defines.svh"
module acc_hot_check import acc_pkg::*; #(
    parameter int NAUX = `ACC_NAUX,
    parameter int TW   = `ACC_TW,
    parameter int CHW  = `ACC_CHW
) (
    // clock and reset
    input  wire logic            ref_clk,
    input  wire logic            rst_n,
    // configuration
    input  wire logic [NAUX-1:0] hot_en,
    input  wire logic [NAUX-1:0] io_mode,
    input  wire logic [NAUX-1:0] ref_sel,
    input  wire logic [NAUX-1:0] hot_clr,
    input  wire logic [TW-1:0]   adc_ratio_thr,
    input  wire logic [TW-1:0]   adc_abs_thr,
    input  wire logic [TW-1:0]   comp_ratio_thr,
    input  wire logic [TW-1:0]   comp_abs_thr,
    // samples
    input  wire logic            sample_valid,
    input  wire logic            sample_comp,
    input  wire logic [CHW-1:0]  sample_chan,
    input  wire logic [TW-1:0]   sample_value,
    // alerts
    output wire logic [NAUX-1:0] alert
);
    typedef struct packed {
        logic [NAUX-1:0] alert;
    } acc_hot_state_t;

    acc_hot_state_t s;
    acc_hot_state_t next_s;
    logic           in_range;
    logic           sel_ratio;
    logic [TW-1:0]  thr;
    logic           hit;

    // threshold choice and compare, clear before set so a hit wins
    always_comb begin
        next_s = s;
        in_range = int'(sample_chan) < NAUX;
        sel_ratio = in_range && ref_sel[sample_chan];
        thr = sample_comp ? (sel_ratio ? comp_ratio_thr : comp_abs_thr)
                          : (sel_ratio ? adc_ratio_thr : adc_abs_thr);
        hit = sample_valid && in_range && hot_en[sample_chan]
              && !io_mode[sample_chan] && (sample_value < thr);
        next_s.alert = s.alert & ~hot_clr;
        if (hit) begin
            next_s.alert[sample_chan] = 1'b1;
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign alert = s.alert;

    hot_enable_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sample_valid && in_range && !hot_en[sample_chan] && !s.alert[sample_chan])
        |=> !s.alert[$past(sample_chan)])
        else $error("disabled aux channel raised a hot alert");

    hot_select_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sample_valid && in_range && hot_en[sample_chan] && !io_mode[sample_chan]
         && !sample_comp && ref_sel[sample_chan] && sample_value < adc_ratio_thr)
        |=> s.alert[$past(sample_chan)])
        else $error("ratiometric hot threshold not applied");

    hot_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (hot_clr != '0 && !hit) |=> ((s.alert & $past(hot_clr)) == '0))
        else $error("hot alert survived its enable clear");

    hot_ignore_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sample_valid && in_range && io_mode[sample_chan] && !s.alert[sample_chan])
        |=> !s.alert[$past(sample_chan)])
        else $error("io mode channel raised a hot alert");
endmodule : acc_hot_check

//--- acc_over_alert.sv
// Purpose: cell overvoltage alert with set and clear thresholds
// Assumes: one cell sample per cycle at most, from the scan engine
// Notes:   set is checked first, so a clear above set cannot mask it
`timescale 1ns/1ps
`include "acc_defines.svh"
module acc_over_alert import acc_pkg::*; #(
    parameter int NCELL = `ACC_NCELL,
    parameter int TW    = `ACC_TW,
    parameter int CW    = `ACC_CELLW
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // thresholds
    input  wire logic [TW-1:0]    set_thr,
    input  wire logic [TW-1:0]    clr_thr,
    // samples
    input  wire logic             sample_valid,
    input  wire logic             sample_unipolar,
    input  wire logic [CW-1:0]    sample_cell,
    input  wire logic [TW-1:0]    sample_value,
    // alerts
    output wire logic [NCELL-1:0] alert
);
    typedef struct packed {
        logic [NCELL-1:0] alert;
    } acc_ov_state_t;

    acc_ov_state_t s;
    acc_ov_state_t next_s;
    logic          take;

    // hysteresis: above set asserts, at or below clear deasserts
    always_comb begin
        next_s = s;
        take = sample_valid && sample_unipolar && (int'(sample_cell) < NCELL);
        if (take) begin
            if (sample_value > set_thr) begin
                next_s.alert[sample_cell] = 1'b1;
            end else if (sample_value <= clr_thr) begin
                next_s.alert[sample_cell] = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign alert = s.alert;

    sequence ov_in_band;
        take && sample_value > clr_thr && sample_value <= set_thr;
    endsequence

    ov_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (take && sample_value > set_thr) |=> s.alert[$past(sample_cell)])
        else $error("over alert not set above set threshold");

    ov_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (take && sample_value <= clr_thr && sample_value <= set_thr)
        |=> !s.alert[$past(sample_cell)])
        else $error("over alert not cleared at clear threshold");

    ov_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ov_in_band |=> (s.alert[$past(sample_cell)] == $past(s.alert[sample_cell])))
        else $error("over alert changed inside hysteresis band");
endmodule : acc_over_alert

//--- acc_top.sv
// Purpose: alert check configuration registers behind an AXI4-Lite slave
// Assumes: scan engine results arrive on ref_clk, one sample a cycle
// Notes:   16-bit registers sit in the low half of each 32-bit word
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "acc_defines.svh"
module acc_top import acc_pkg::*; #(
    parameter int AW = 12
) (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // axi4-lite write address and data
    input  wire logic [AW-1:0]         s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output wire logic                  s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output wire logic                  s_axi_wready,
    // axi4-lite write response
    output wire logic [1:0]            s_axi_bresp,
    output wire logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read
    input  wire logic [AW-1:0]         s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output wire logic                  s_axi_arready,
    output wire logic [31:0]           s_axi_rdata,
    output wire logic [1:0]            s_axi_rresp,
    output wire logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // aux thresholds held elsewhere
    input  wire logic [`ACC_TW-1:0]    aux_ratio_hot_threshold,
    input  wire logic [`ACC_TW-1:0]    aux_abs_hot_threshold,
    input  wire logic [`ACC_TW-1:0]    comparator_ratio_hot_threshold,
    input  wire logic [`ACC_TW-1:0]    comparator_abs_hot_threshold,
    // aux samples
    input  wire logic                  aux_sample_valid,
    input  wire logic                  aux_sample_comp,
    input  wire logic [`ACC_CHW-1:0]   aux_sample_chan,
    input  wire logic [`ACC_TW-1:0]    aux_sample_value,
    // cell samples
    input  wire logic                  cell_sample_valid,
    input  wire logic                  cell_sample_unipolar,
    input  wire logic [`ACC_CELLW-1:0] cell_sample_index,
    input  wire logic [`ACC_TW-1:0]    cell_sample_value,
    // calibration range check results
    input  wire logic [`ACC_NCAL-1:0]  cal_range_fail,
    // alerts
    output wire logic [`ACC_NAUX-1:0]  aux_hot_alert,
    output wire logic [`ACC_NCELL-1:0] cell_over_alert,
    output wire logic                  adc_offset_cal_alert,
    output wire logic                  ramp_offset_cal_alert,
    output wire logic                  ratio_offset_cal_alert,
    output wire logic                  pyramid_gain_cal_alert,
    output wire logic                  ramp_gain_cal_alert,
    output wire logic                  irq
);
    acc_regs_t                s;
    acc_regs_t                next_s;
    logic [15:0]              wv;
    logic                     wr_go;
    logic [`ACC_NSTAT-1:0]    rclr;
    logic [`ACC_NSTAT-1:0]    events;
    logic [`ACC_NCAL-1:0]     cal_mask;
    logic [`ACC_NAUX-1:0]     hot_alert;
    logic [`ACC_NCELL-1:0]    over_alert;

    // true when a byte address equals the first byte of the word of a register index
    function automatic logic acc_at(input logic [AW-1:0] addr,
                                    input logic [7:0]    idx);
        acc_at = (addr == AW'({idx, 2'h0}));
    endfunction : acc_at

    // merge write data into a 16-bit register through the byte strobes
    function automatic logic [15:0] acc_merge(input logic [15:0] old,
                                              input logic [15:0] data,
                                              input logic [1:0]  strb);
        acc_merge = {strb[1] ? data[15:8] : old[15:8],
                     strb[0] ? data[7:0]  : old[7:0]};
    endfunction : acc_merge

    // bus handshakes, register writes, reads, alerts and interrupt
    always_comb begin
        next_s = s;
        wv = '0;
        rclr = '0;
        cal_mask = s.irq_mask[`ACC_ST_CAL_LSB +: `ACC_NCAL];
        wr_go = s.aw_held && s.w_held && !s.bvalid;
        // address and data may come in either order
        if (s.awready && s_axi_awvalid) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s.wready && s_axi_wvalid) begin
            next_s.w_held = 1'b1;
            next_s.w_data = s_axi_wdata[15:0];
            next_s.w_strb = s_axi_wstrb[1:0];
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        // perform the write once both halves are held
        if (wr_go) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = `ACC_RESP_OKAY;
            if (acc_at(s.aw_addr, `ACC_IDX_HOT_EN)) begin
                wv = acc_merge(16'(s.hot_en), s.w_data, s.w_strb);
                next_s.hot_en = wv[`ACC_NAUX-1:0];
            end else if (acc_at(s.aw_addr, `ACC_IDX_CAL_FRC)) begin
                wv = acc_merge(16'(s.cal_frc), s.w_data, s.w_strb);
                next_s.cal_frc = wv[`ACC_NCAL-1:0];
            end else if (acc_at(s.aw_addr, `ACC_IDX_OV_CLR)) begin
                wv = acc_merge(16'(s.ov_clr) << `ACC_THR_LSB, s.w_data, s.w_strb);
                next_s.ov_clr = wv[`ACC_THR_LSB +: `ACC_TW];
            end else if (acc_at(s.aw_addr, `ACC_IDX_OV_SET)) begin
                wv = acc_merge(16'(s.ov_set) << `ACC_THR_LSB, s.w_data, s.w_strb);
                next_s.ov_set = wv[`ACC_THR_LSB +: `ACC_TW];
            end else if (acc_at(s.aw_addr, `ACC_IDX_AUX_CFG)) begin
                wv = acc_merge((16'(s.io_mode) << `ACC_IOMODE_LSB)
                               | (16'(s.ref_sel) << `ACC_REFSEL_LSB),
                               s.w_data, s.w_strb);
                next_s.ref_sel = wv[`ACC_REFSEL_LSB +: `ACC_NAUX];
                next_s.io_mode = wv[`ACC_IOMODE_LSB +: `ACC_NAUX];
            end else if (acc_at(s.aw_addr, `ACC_IDX_IRQ_MASK)) begin
                wv = acc_merge(16'(s.irq_mask), s.w_data, s.w_strb);
                next_s.irq_mask = wv[`ACC_NSTAT-1:0];
            end else if (!acc_at(s.aw_addr, `ACC_IDX_IRQ_STAT)) begin
                next_s.bresp = `ACC_RESP_SLVERR;
            end
        end
        // enable bits going from one to zero clear their hot alerts
        next_s.hot_clr = s.hot_en & ~next_s.hot_en;
        // read: data is captured when the address is taken
        if (s.arready && s_axi_arvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = `ACC_RESP_OKAY;
            next_s.rdata = '0;
            if (acc_at(s_axi_araddr, `ACC_IDX_HOT_EN)) begin
                next_s.rdata = 32'(s.hot_en);
            end else if (acc_at(s_axi_araddr, `ACC_IDX_CAL_FRC)) begin
                next_s.rdata = 32'(s.cal_frc);
            end else if (acc_at(s_axi_araddr, `ACC_IDX_OV_CLR)) begin
                next_s.rdata = 32'(s.ov_clr) << `ACC_THR_LSB;
            end else if (acc_at(s_axi_araddr, `ACC_IDX_OV_SET)) begin
                next_s.rdata = 32'(s.ov_set) << `ACC_THR_LSB;
            end else if (acc_at(s_axi_araddr, `ACC_IDX_AUX_CFG)) begin
                next_s.rdata = (32'(s.io_mode) << `ACC_IOMODE_LSB)
                               | (32'(s.ref_sel) << `ACC_REFSEL_LSB);
            end else if (acc_at(s_axi_araddr, `ACC_IDX_IRQ_STAT)) begin
                next_s.rdata = 32'(s.irq_stat);
                rclr = s.irq_stat;
            end else if (acc_at(s_axi_araddr, `ACC_IDX_IRQ_MASK)) begin
                next_s.rdata = 32'(s.irq_mask);
            end else begin
                next_s.rresp = `ACC_RESP_SLVERR;
            end
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        // calibration alerts: real range check, or force when unmasked
        next_s.cal_alert = cal_range_fail | (s.cal_frc & cal_mask);
        // sticky status; a new event wins over the read clear
        events = '0;
        events[`ACC_ST_HOT_LSB +: `ACC_NAUX] = hot_alert;
        events[`ACC_ST_OV_BIT] = |over_alert;
        events[`ACC_ST_CAL_LSB +: `ACC_NCAL] = s.cal_alert;
        next_s.irq_stat = (s.irq_stat & ~rclr) | events;
        next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
        // ready flags follow the held halves and pending answers
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready = !next_s.w_held && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
    end

    // state register with documented reset values
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s <= '0;
            s.ov_clr <= `ACC_THR_RESET;
            s.ov_set <= `ACC_THR_RESET;
        end else begin
            s <= next_s;
        end
    end

    // aux hot checks
    acc_hot_check u_hot (
        .ref_clk        (ref_clk),
        .rst_n          (rst_n),
        .hot_en         (s.hot_en),
        .io_mode        (s.io_mode),
        .ref_sel        (s.ref_sel),
        .hot_clr        (s.hot_clr),
        .adc_ratio_thr  (aux_ratio_hot_threshold),
        .adc_abs_thr    (aux_abs_hot_threshold),
        .comp_ratio_thr (comparator_ratio_hot_threshold),
        .comp_abs_thr   (comparator_abs_hot_threshold),
        .sample_valid   (aux_sample_valid),
        .sample_comp    (aux_sample_comp),
        .sample_chan    (aux_sample_chan),
        .sample_value   (aux_sample_value),
        .alert          (hot_alert)
    );

    // cell overvoltage alerts
    acc_over_alert u_over (
        .ref_clk         (ref_clk),
        .rst_n           (rst_n),
        .set_thr         (s.ov_set),
        .clr_thr         (s.ov_clr),
        .sample_valid    (cell_sample_valid),
        .sample_unipolar (cell_sample_unipolar),
        .sample_cell     (cell_sample_index),
        .sample_value    (cell_sample_value),
        .alert           (over_alert)
    );

    // outputs straight from flops
    assign s_axi_awready          = s.awready;
    assign s_axi_wready           = s.wready;
    assign s_axi_bresp            = s.bresp;
    assign s_axi_bvalid           = s.bvalid;
    assign s_axi_arready          = s.arready;
    assign s_axi_rdata            = s.rdata;
    assign s_axi_rresp            = s.rresp;
    assign s_axi_rvalid           = s.rvalid;
    assign aux_hot_alert          = hot_alert;
    assign cell_over_alert        = over_alert;
    assign adc_offset_cal_alert   = s.cal_alert[4];
    assign ramp_offset_cal_alert  = s.cal_alert[3];
    assign ratio_offset_cal_alert = s.cal_alert[2];
    assign pyramid_gain_cal_alert = s.cal_alert[1];
    assign ramp_gain_cal_alert    = s.cal_alert[0];
    assign irq                    = s.irq;

    sequence hot_drop;
        s.hot_clr != '0;
    endsequence

    cal_force_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s.cal_frc != '0)
        |=> ((s.cal_alert & $past(s.cal_frc & cal_mask)) == $past(s.cal_frc & cal_mask)))
        else $error("unmasked force bit did not raise its alert");

    cal_reset_a: assert property (@(posedge ref_clk)
        !rst_n |=> (s.cal_frc == '0 && s.cal_alert == '0))
        else $error("force bits not zero after reset");

    cal_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s.cal_frc == '0 && cal_range_fail == '0) |=> (s.cal_alert == '0))
        else $error("calibration alert stuck with force cleared");

    hot_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hot_drop |-> ((s.hot_clr & s.hot_en) == '0)
        ##1 ((hot_alert & $past(s.hot_clr)) == '0))
        else $error("hot alert kept after enable clear");

    ov_store_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_go && acc_at(s.aw_addr, `ACC_IDX_OV_CLR) && s.w_strb == 2'h3)
        |=> (s.ov_clr == $past(s.w_data[15:2])) && s.bvalid)
        else $error("clear threshold not stored from write");
endmodule : acc_top

//--- acc_top_bench.sv
// Purpose: self-checking bench for the alert check config block
// Assumes: acc_pkg is compiled first
// Notes:   integer models are compared with the design after each step
`timescale 1ns/1ps
`include "acc_defines.svh"
`define ACC_CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module acc_top_bench import acc_pkg::*;;
    // drives and models
    logic        ref_clk = 0, rst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic        av = 0, ac = 0, cv = 0, cu = 0, u;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [2:0]  ach = 0;
    logic [3:0]  cix = 0, strb = 4'hf;
    logic [4:0]  fail = 0, f;
    logic [5:0]  en, rs, io, hot_m = 0;
    logic [13:0] aval = 0, cval = 0, t_ar = 0, t_aa = 0, t_cr = 0, t_ca = 0, ov_m = 0, th;
    // design outputs
    wire         awready, wready, bvalid, arready, rvalid, irq;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [5:0]  hot;
    wire  [13:0] ov;
    wire  [4:0]  cal;
    int          miscompares = 0, check_count = 0, c, v;

    acc_top i_acc_top (
        .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .aux_ratio_hot_threshold(t_ar), .aux_abs_hot_threshold(t_aa),
        .comparator_ratio_hot_threshold(t_cr), .comparator_abs_hot_threshold(t_ca),
        .aux_sample_valid(av), .aux_sample_comp(ac), .aux_sample_chan(ach),
        .aux_sample_value(aval), .cell_sample_valid(cv), .cell_sample_unipolar(cu),
        .cell_sample_index(cix), .cell_sample_value(cval), .cal_range_fail(fail),
        .aux_hot_alert(hot), .cell_over_alert(ov), .adc_offset_cal_alert(cal[4]),
        .ramp_offset_cal_alert(cal[3]), .ratio_offset_cal_alert(cal[2]),
        .pyramid_gain_cal_alert(cal[1]), .ramp_gain_cal_alert(cal[0]), .irq(irq));

    always #25 ref_clk = ~ref_clk;

    // one write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] i, input logic [15:0] d, input logic [1:0] r = 2'h0);
        @(posedge ref_clk);
        awaddr <= {2'b00, i, 2'b00};
        wdata <= {16'h0000, d};
        awv <= 1;
        wv <= 1;
        bready <= 1;
        do begin
            @(posedge ref_clk);
            if (awready) awv <= 0;
            if (wready) wv <= 0;
        end while (bvalid !== 1'b1);
        bready <= 0;
        `ACC_CHK("bresp", {1'b1, r}, {bvalid, bresp})
    endtask : wr

    // one read, compared unless k is low
    task automatic rd(input logic [7:0] i, input logic [15:0] e, input logic [1:0] r = 2'h0,
                      input bit k = 1);
        @(posedge ref_clk);
        araddr <= {2'b00, i, 2'b00};
        arv <= 1;
        rready <= 1;
        do begin
            @(posedge ref_clk);
            if (arready) arv <= 0;
        end while (rvalid !== 1'b1);
        rready <= 0;
        if (k) `ACC_CHK("rdata", {1'b1, r, 16'h0000, e}, {rvalid, rresp, rdata})
    endtask : rd

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done

    // cut a hang short
    initial begin
        #2_000_000;
        miscompares++;
        test_done();
    end

    initial begin
        void'($urandom(45));
        repeat (12) @(posedge ref_clk);
        rst_n <= 1;
        t_ar <= 14'($urandom_range(9000, 1000));
        t_aa <= 14'($urandom_range(9000, 1000));
        t_cr <= 14'($urandom_range(9000, 1000));
        t_ca <= 14'($urandom_range(9000, 1000));
        // reset values, field widths, unmapped place
        rd(`ACC_IDX_HOT_EN, 16'h0000);
        rd(`ACC_IDX_CAL_FRC, 16'h0000);
        rd(`ACC_IDX_OV_CLR, 16'hfffc);
        rd(`ACC_IDX_OV_SET, 16'hfffc);
        // low byte strobe only: upper byte of the threshold survives
        strb <= 4'h1;
        wr(`ACC_IDX_OV_CLR, 16'h0000);
        strb <= 4'hf;
        rd(`ACC_IDX_OV_CLR, 16'hff00);
        rd(8'h10, 16'h0000, `ACC_RESP_SLVERR);
        wr(8'h10, 16'hffff, `ACC_RESP_SLVERR);
        wr(`ACC_IDX_CAL_FRC, 16'hffff);
        rd(`ACC_IDX_CAL_FRC, 16'h001f);
        $display("registers test done");
        // force only where unmasked, else follow the range check
        wr(`ACC_IDX_IRQ_MASK, 16'h0f00);
        repeat (10) begin
            f = 5'($urandom);
            @(posedge ref_clk);
            fail <= 5'($urandom);
            wr(`ACC_IDX_CAL_FRC, {11'h000, f});
            repeat (2) @(posedge ref_clk);
            #1 `ACC_CHK("cal", fail | (f & 5'h1e), cal)
        end
        @(posedge ref_clk);
        fail <= 5'h00;
        wr(`ACC_IDX_CAL_FRC, 16'h0001);
        repeat (3) @(posedge ref_clk);
        rd(`ACC_IDX_IRQ_STAT, 16'h0000, `ACC_RESP_OKAY, 0);
        rd(`ACC_IDX_IRQ_STAT, 16'h0000);
        `ACC_CHK("irq", 1'b0, irq)
        wr(`ACC_IDX_CAL_FRC, 16'h0010);
        repeat (3) @(posedge ref_clk);
        `ACC_CHK("irq", 1'b1, irq)
        wr(`ACC_IDX_CAL_FRC, 16'h0000);
        repeat (3) @(posedge ref_clk);
        `ACC_CHK("cal", 5'h00, cal)
        rd(`ACC_IDX_IRQ_STAT, 16'h0800);
        rd(`ACC_IDX_IRQ_STAT, 16'h0000);
        `ACC_CHK("irq", 1'b0, irq)
        $display("calibration test done");
        // over alert with hysteresis between 100 and 200
        wr(`ACC_IDX_OV_CLR, 16'h0190);
        wr(`ACC_IDX_OV_SET, 16'h0320);
        repeat (300) begin
            c = $urandom_range(13, 0);
            v = $urandom_range(205, 95);
            u = ($urandom_range(3, 0) != 0);
            @(posedge ref_clk);
            cv <= 1;
            cu <= u;
            cix <= 4'(c);
            cval <= 14'(v);
            if (u) ov_m[c] = (v > 200) | ((v > 100) & ov_m[c]);
            @(posedge ref_clk);
            cv <= 0;
            #1 `ACC_CHK("over", ov_m, ov)
        end
        $display("over test done");
        // hot checks in rounds of random enables, channel 5 in io mode
        rs = 6'($urandom);
        io = 6'h20;
        wr(`ACC_IDX_AUX_CFG, {2'b00, io, 2'b00, rs});
        repeat (6) begin
            en = 6'($urandom);
            wr(`ACC_IDX_HOT_EN, {10'h000, en});
            hot_m = hot_m & en;
            repeat (3) @(posedge ref_clk);
            #1 `ACC_CHK("hot", hot_m, hot)
            repeat (30) begin
                c = $urandom_range(6, 0);
                v = $urandom_range(9999, 0);
                u = $urandom_range(1, 0);
                th = u ? (rs[c % 6] ? t_cr : t_ca) : (rs[c % 6] ? t_ar : t_aa);
                @(posedge ref_clk);
                av <= 1;
                ac <= u;
                ach <= 3'(c);
                aval <= 14'(v);
                if (c < 6 && en[c % 6] && !io[c % 6] && v < th) hot_m[c] = 1;
                @(posedge ref_clk);
                av <= 0;
                #1 `ACC_CHK("hot", hot_m, hot)
            end
        end
        rd(`ACC_IDX_HOT_EN, {10'h000, en});
        $display("hot test done");
        test_done();
    end
endmodule : acc_top_bench
